// file: logic/clock_ctrl_defines.svh
// Constants of the double-speed clock control block: SFR offsets, field
// positions, reset values and oscillator period counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CLOCK_CTRL_DEFINES_SVH
`define CLOCK_CTRL_DEFINES_SVH

// SFR byte addresses of the two clock control registers.
`define CLOCK_DIVIDE_CONTROL_ADDR        8'h8F
`define SERIAL_PERIPH_CLOCK_CONTROL_ADDR 8'h9F

// Reset values of both registers.
`define CLOCK_DIVIDE_CONTROL_RST         8'h00
`define SERIAL_PERIPH_CLOCK_CONTROL_RST  8'h00

// Field positions in clock_divide_control.
`define CAN_CLOCK_SLOW_SEL_BIT           7
`define WATCHDOG_CLOCK_SLOW_SEL_BIT      6
`define COUNTER_ARRAY_CLOCK_SLOW_SEL_BIT 5
`define UART_CLOCK_SLOW_SEL_BIT          4
`define TIMER2_CLOCK_SLOW_SEL_BIT        3
`define TIMER1_CLOCK_SLOW_SEL_BIT        2
`define TIMER0_CLOCK_SLOW_SEL_BIT        1
`define CPU_DOUBLE_SPEED_BIT             0

// Field position in serial_periph_clock_control.
`define SPI_CLOCK_SLOW_SEL_BIT           0

// Oscillator periods per machine cycle in each speed.
`define STD_OSC_PERIODS                  12
`define X2_OSC_PERIODS                   6

// Last value of the oscillator period counter and the double-speed midpoint.
`define OSC_COUNT_LAST                   4'hB
`define OSC_COUNT_MID                    4'h5

`endif

// file: logic/clock_ctrl_pkg.sv
// Types shared by the clock control modules.
// Assumes the defines header sits beside it on the include path.
`include "clock_ctrl_defines.svh"

package clock_ctrl_pkg;

  typedef logic [7:0] sfr_byte_t;
  typedef logic [3:0] osc_count_t;

  // Speed of the CPU clock.
  typedef enum logic {
    standard_speed_mode = 1'b0,
    double_speed_mode   = 1'b1
  } cpu_speed_t;

endpackage

// file: logic/clock_phase_if.sv
// Carrier between the clock control core and its cycle-enable generator.
// Assumes both ends run on the crystal clock.
`timescale 1ns/1ps

interface clock_phase_if;
  import clock_ctrl_pkg::*;

  osc_count_t osc_count;  // Oscillator period position, 0 to 11.
  logic [8:0] fast;       // Bit 8 CPU, bits 7..0 peripherals; 1 means 6 periods.
  logic [8:0] cycle_end;  // Registered one-cycle enables, same bit order.

  modport ctrl (output osc_count, output fast, input cycle_end);
  modport gen  (input osc_count, input fast, output cycle_end);
endinterface

// file: logic/cycle_enable_gen.sv
// Turns the oscillator period position and per-clock speed into cycle
// enables, one pulse per machine or peripheral cycle.
// Assumes osc_count runs 0..11 and speeds only change on even positions.
`timescale 1ns/1ps
`include "clock_ctrl_defines.svh"

module cycle_enable_gen
  import clock_ctrl_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst_n,
  clock_phase_if.gen  ph
);

  // A cycle ends at position 11 always, and also at 5 when the clock is fast.
  function automatic logic cycle_done(input logic fast_f, input osc_count_t cnt);
    cycle_done = (cnt == `OSC_COUNT_LAST) || (fast_f && (cnt == `OSC_COUNT_MID));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registered enables, so every enable leaves a flip-flop.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ph.cycle_end <= 9'h000;
    end else begin
      for (int i = 0; i < 9; i++) begin
        ph.cycle_end[i] <= cycle_done(ph.fast[i], ph.osc_count);
      end
    end
  end

endmodule

// file: logic/double_speed_clock_control.sv
// Double-speed clock control: two clock control SFRs, the crystal
// divide-by-two and the CPU and peripheral cycle enables.
// Assumes clk_sys is the crystal input and the SFR port is the core's bus.
//
// Functional notes
// - Divide crystal by two; software may bypass (no bypass here: crystal_div2 always toggles).
// - CPU starts standard speed after reset.
// - Standard uses 12 periods; double uses 6.
// - Peripheral select in double speed: clear 6, set 12 periods; in standard speed all peripherals use 12.
// - Control bits: CAN, watchdog, PCA, UART, timers, CPU.
// - Second register bit 0 selects SPI clock.
// - Second register upper bits reserved, never set.
// - CPU speed change applied on divided edge.
// - Security-byte fuse may start double speed.
// - Both registers reset to zero.
// - Clock registers are not bit-addressable.
`timescale 1ns/1ps
`include "clock_ctrl_defines.svh"


module double_speed_clock_control
  import clock_ctrl_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire logic      rst_n,
  input  wire sfr_byte_t sfr_addr,
  input  wire sfr_byte_t sfr_wdata,
  input  wire logic      sfr_wr,
  input  wire logic      sfr_rd,
  input  wire sfr_byte_t sfr_bit_addr,
  input  wire logic      sfr_bit_wdata,
  input  wire logic      sfr_bit_wr,
  input  wire logic      boot_double_speed_fuse,
  output sfr_byte_t      sfr_rdata,
  output logic           sfr_rd_hit,
  output logic           crystal_div2,
  output cpu_speed_t     cpu_speed,
  output logic           cpu_cycle_en,
  output logic [7:0]     periph_cycle_en
);

  sfr_byte_t  clock_divide_control_r;
  logic       spi_clock_slow_sel_r;
  logic       boot_pend_r;
  logic       div_r;
  osc_count_t cnt_r;
  cpu_speed_t speed_act_r;
  logic [7:0] slow_act_r;
  sfr_byte_t  rdata_r;
  logic       rd_hit_r;

  clock_phase_if ph ();

  ////////////////////////////////////////////////////////////////////////////
  // Register writes. Only byte writes reach these registers; bit writes of
  // the core target addresses ending in 0 or 8 and never land here.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clock_divide_control_r <= `CLOCK_DIVIDE_CONTROL_RST;
      spi_clock_slow_sel_r   <= 1'b0;
    end else begin
      if (boot_pend_r && boot_double_speed_fuse) begin
        clock_divide_control_r[`CPU_DOUBLE_SPEED_BIT] <= 1'b1;
      end
      if (sfr_wr && sfr_addr == `CLOCK_DIVIDE_CONTROL_ADDR) begin
        clock_divide_control_r <= sfr_wdata;
      end
      if (sfr_wr && sfr_addr == `SERIAL_PERIPH_CLOCK_CONTROL_ADDR) begin
        spi_clock_slow_sel_r <= sfr_wdata[`SPI_CLOCK_SLOW_SEL_BIT];
      end
    end
  end

  // The fuse is sampled once, in the first cycle after reset release.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      boot_pend_r <= 1'b1;
    end else begin
      boot_pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, answered one cycle later. Reserved bits read as zero;
  // other SFR addresses answer zero without a hit.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_r  <= 8'h00;
      rd_hit_r <= 1'b0;
    end else begin
      rdata_r  <= 8'h00;
      rd_hit_r <= 1'b0;
      if (sfr_rd && sfr_addr == `CLOCK_DIVIDE_CONTROL_ADDR) begin
        rdata_r  <= clock_divide_control_r;
        rd_hit_r <= 1'b1;
      end else if (sfr_rd && sfr_addr == `SERIAL_PERIPH_CLOCK_CONTROL_ADDR) begin
        rdata_r  <= {7'h00, spi_clock_slow_sel_r};
        rd_hit_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divide-by-two and the oscillator period position. The position keeps
  // counting through mode changes so the phase generator never restarts.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_r <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      div_r <= ~div_r;
      cnt_r <= (cnt_r == `OSC_COUNT_LAST) ? 4'h0 : cnt_r + 4'h1;
    end
  end

  // Speeds take effect only as the divided clock rises, so a switch never
  // leaves a half-length period on the CPU or any peripheral.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      speed_act_r <= standard_speed_mode;
      slow_act_r  <= 8'h00;
    end else if (!div_r) begin
      speed_act_r <= cpu_speed_t'(clock_divide_control_r[`CPU_DOUBLE_SPEED_BIT]);
      slow_act_r  <= {clock_divide_control_r[7:1], spi_clock_slow_sel_r};
    end
  end

  // Peripheral select counts only in double speed; otherwise all run at 12.
  assign ph.osc_count = cnt_r;
  assign ph.fast      = {speed_act_r == double_speed_mode,
                         {8{speed_act_r == double_speed_mode}} & ~slow_act_r};

  cycle_enable_gen u_gen (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .ph      (ph)
  );

  // Outputs straight from flip-flops.
  assign sfr_rdata       = rdata_r;
  assign sfr_rd_hit      = rd_hit_r;
  assign crystal_div2    = div_r;
  assign cpu_speed       = speed_act_r;
  assign cpu_cycle_en    = ph.cycle_end[8];
  assign periph_cycle_en = ph.cycle_end[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks. Registers hold their reset values at the first edge after release,
  // so checks that compare with the past start one edge later.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_reset_regs_zero: assert property (
    !$past(rst_n) |-> clock_divide_control_r == 8'h00 && !spi_clock_slow_sel_r &&
                      speed_act_r == standard_speed_mode)
    else $error("Clock control registers not zero after reset.");

  a_div_toggles: assert property (
    $past(rst_n) |-> div_r != $past(div_r))
    else $error("Divide-by-two stage did not toggle.");

  a_std_cpu_slot: assert property (
    cpu_cycle_en && $past(speed_act_r) == standard_speed_mode |-> $past(cnt_r) == 4'hB)
    else $error("Standard-speed CPU cycle not at 12 periods.");

  a_x2_cpu_mid: assert property (
    speed_act_r == double_speed_mode && cnt_r == 4'h5 |=> cpu_cycle_en ##1 !cpu_cycle_en)
    else $error("Double-speed CPU cycle missing at 6 periods.");

  a_std_periph_all: assert property (
    speed_act_r == standard_speed_mode && cnt_r == 4'h5 |=> periph_cycle_en == 8'h00)
    else $error("Peripheral fast in standard speed.");

  a_slow_can_mid: assert property (
    speed_act_r == double_speed_mode && slow_act_r[7] && cnt_r == 4'h5
      |=> !periph_cycle_en[7])
    else $error("Slow CAN clock pulsed at 6 periods.");

  a_fast_spi_mid: assert property (
    speed_act_r == double_speed_mode && !slow_act_r[0] && cnt_r == 4'h5
      |=> periph_cycle_en[0])
    else $error("Fast SPI clock missing at 6 periods.");

  a_speed_on_edge: assert property (
    speed_act_r != $past(speed_act_r) |-> !$past(div_r))
    else $error("CPU speed changed off the divided edge.");

  a_sel_on_edge: assert property (
    slow_act_r != $past(slow_act_r) |-> !$past(div_r))
    else $error("Peripheral select changed off the divided edge.");

  // The register takes the write at once; the divided edge may then be one or
  // two edges away, so the new speed is visible three edges after the write.
  a_write_to_speed: assert property (
    sfr_wr && sfr_addr == 8'h8F && !boot_pend_r ##1 !sfr_wr[*3]
      |-> speed_act_r == cpu_speed_t'($past(sfr_wdata[0], 3)))
    else $error("CPU speed write not applied within three cycles.");

  a_reserved_zero: assert property (
    sfr_rd && sfr_addr == 8'h9F |=> sfr_rd_hit && sfr_rdata[7:1] == 7'h00)
    else $error("Reserved clock control bits read nonzero.");

  a_bit_write_ignored: assert property (
    sfr_bit_wr && !sfr_wr && !boot_pend_r
      |=> $stable(clock_divide_control_r) && $stable(spi_clock_slow_sel_r))
    else $error("Bit write changed a clock control register.");

  a_fuse_boot: assert property (
    boot_pend_r && boot_double_speed_fuse && !sfr_wr
      |-> ##[1:3] speed_act_r == double_speed_mode)
    else $error("Fuse did not start double speed.");

  a_count_range: assert property (
    cnt_r <= `OSC_COUNT_LAST)
    else $error("Oscillator period position left its range.");

  c_enter_x2: cover property (speed_act_r == standard_speed_mode ##1
                              speed_act_r == double_speed_mode);
  c_leave_x2: cover property (speed_act_r == double_speed_mode ##1
                              speed_act_r == standard_speed_mode);
  c_mixed_periph: cover property (speed_act_r == double_speed_mode && slow_act_r == 8'h0F);
  c_bit_write: cover property (sfr_bit_wr && sfr_bit_wdata);
  c_fuse_boot: cover property (boot_pend_r && boot_double_speed_fuse);

endmodule

// file: testbench/double_speed_clock_control_test.sv
// Self-checking bench for the double-speed clock control block.
// Assumes a single crystal clock; the bench drives every port itself.
`timescale 1ns/1ps

module double_speed_clock_control_test
  import clock_ctrl_pkg::*;
;
  typedef struct packed {
    sfr_byte_t addr;
    sfr_byte_t wdata;
    sfr_byte_t rdata;
    logic      hit;
  } row_t;

  localparam int   ROWS = 5;
  localparam row_t TABLE [ROWS] = '{
    '{8'h8F, 8'hA5, 8'hA5, 1'b1}, '{8'h9F, 8'h01, 8'h01, 1'b1},
    '{8'h9F, 8'h00, 8'h00, 1'b1}, '{8'h8F, 8'h00, 8'h00, 1'b1},
    '{8'h8E, 8'h55, 8'h00, 1'b0}};

  logic       clk_sys, rst_n, sfr_wr, sfr_rd, sfr_bit_wdata, sfr_bit_wr, fuse;
  sfr_byte_t  sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata;
  logic       sfr_rd_hit, crystal_div2, cpu_cycle_en, prev_div;
  cpu_speed_t cpu_speed, prev_speed;
  logic [7:0] periph_cycle_en;
  logic [8:0] sig;
  int         fails, checks, cyc, up_cnt;

  assign sig = {cpu_cycle_en, periph_cycle_en};

  double_speed_clock_control dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_bit_addr(sfr_bit_addr),
    .sfr_bit_wdata(sfr_bit_wdata), .sfr_bit_wr(sfr_bit_wr),
    .boot_double_speed_fuse(fuse), .sfr_rdata(sfr_rdata), .sfr_rd_hit(sfr_rd_hit),
    .crystal_div2(crystal_div2), .cpu_speed(cpu_speed), .cpu_cycle_en(cpu_cycle_en),
    .periph_cycle_en(periph_cycle_en));

  ////////////////////////////////////////////////////////////////////////////
  // Crystal clock, 5 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Hang guard; the tests need a few thousand cycles at most.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  // Mid-cycle watch of the divider and of where speed changes land.
  always @(negedge clk_sys) begin
    up_cnt = rst_n ? ((up_cnt < 4) ? up_cnt + 1 : 4) : 0;
    if (up_cnt >= 3) chk({7'h00, crystal_div2 ^ prev_div}, 8'h01);
    if (up_cnt >= 2 && cpu_speed !== prev_speed)
      chk({6'h00, prev_div, crystal_div2}, 8'h01);
    prev_div   = crystal_div2;
    prev_speed = cpu_speed;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reset_dut(input logic f);
    @(posedge clk_sys);
    #1 rst_n = 1'b0;
    fuse = f;
    repeat (4) @(posedge clk_sys);
    #1 rst_n = 1'b1;
  endtask

  task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
    @(posedge clk_sys);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk_sys);
    #1 sfr_wr = 1'b0;
  endtask

  // Read data stands for the one cycle after the strobe is taken.
  task automatic rd(input sfr_byte_t a, input sfr_byte_t exp, input logic hit);
    @(posedge clk_sys);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk_sys);
    #1 sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
    chk({7'h00, sfr_rd_hit}, {7'h00, hit});
  endtask

  // Cycles between two successive pulses of one enable bit.
  task automatic per(input int idx, input int exp);
    int n;
    int t;
    n = 0;
    t = 0;
    do begin @(posedge clk_sys); #1 t++; end while (sig[idx] !== 1'b1 && t < 40);
    do begin @(posedge clk_sys); #1 n++; end while (sig[idx] !== 1'b1 && n < 40);
    chk(8'(n), 8'(exp));
  endtask

  task automatic all_per(input int cpu, input int k, input int slow);
    per(8, cpu);
    for (int j = 0; j < 8; j++) per(j, (j == k) ? slow : 6);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, sfr_wr, sfr_rd, sfr_bit_wdata, sfr_bit_wr, fuse} = '0;
    {sfr_addr, sfr_wdata, sfr_bit_addr} = '0;
    {fails, checks, cyc, up_cnt} = '0;
    reset_dut(1'b0);
    chk({7'h00, cpu_speed}, 8'h00);
    rd(8'h8F, 8'h00, 1'b1);
    rd(8'h9F, 8'h00, 1'b1);
    for (int r = 0; r < ROWS; r++) begin
      wr(TABLE[r].addr, TABLE[r].wdata);
      rd(TABLE[r].addr, TABLE[r].rdata, TABLE[r].hit);
    end
    // Standard mode: selects set but ignored, everything at 12.
    wr(8'h8F, 8'hFE);
    wr(8'h9F, 8'h01);
    for (int j = 0; j < 9; j++) per(j, 12);
    // Bit writes must not reach clock_divide_control at 8F; only that register is written and read back.
    @(posedge clk_sys);
    #1 {sfr_bit_addr, sfr_bit_wdata, sfr_bit_wr} = {8'h8F, 1'b1, 1'b1};
    @(posedge clk_sys);
    #1 sfr_bit_wr = 1'b0;
    rd(8'h8F, 8'hFE, 1'b1);
    // One slow select at a time in double speed maps to one enable.
    for (int k = 0; k < 8; k++) begin
      wr(8'h9F, (k == 0) ? 8'h01 : 8'h00);
      wr(8'h8F, 8'(1 << k) | 8'h01);
      repeat (4) @(posedge clk_sys);
      #1 chk({7'h00, cpu_speed}, 8'h01);
      all_per(6, k, 12);
    end
    wr(8'h8F, 8'h00);
    repeat (4) @(posedge clk_sys);
    #1 chk({7'h00, cpu_speed}, 8'h00);
    per(8, 12);
    // Fuse starts the core in double speed; a later plain reset does not.
    reset_dut(1'b1);
    repeat (4) @(posedge clk_sys);
    #1 chk({7'h00, cpu_speed}, 8'h01);
    rd(8'h8F, 8'h01, 1'b1);
    per(8, 6);
    reset_dut(1'b0);
    repeat (4) @(posedge clk_sys);
    #1 chk({7'h00, cpu_speed}, 8'h00);
    per(8, 12);
    tally_and_finish();
  end
endmodule
